// file: hw/fdd_ctl_cfg.svh
// constants for the drive control logic: offsets, straps, timing
// assumes a 250 MHz ref_clk; included by the top and the test bench
//
// What this block does
// RL1: write and erase gates need notch, host write gate and selection.
// RL2: selected side head common goes high while write or erase gate on.
// RL3: tunnel head delays erase behind write by a counter.
// RL4: straddle head erase follows write gate with no delay.
// RL5: each write data pulse flips which of two write drivers is on.
// RL6: no read data pulses while a write driver is active.
// RL7: time domain filter drops saddle pulses within 2.4 us.
// RL8: filtered read data leaves through a three-state driver.
// RL9: low voltage holds write and erase off and inhibits control.
// RL10: retriggered index counter gives speed ok above half speed.
// RL11: ready set on second index after speed ok, driven to host.
// RL12: direction sampled at every step pulse and held.
// RL13: second internal step about 3 ms after step trailing edge.
// RL14: direction and steps become 1-2 phase drive with brief overlap.
// RL15: rest on phase a for even tracks, a bar for odd.
// RL16: 75 ms over-drive timer retriggered by each internal step.
// RL17: spindle runs from motor on through a strapped gate.
// RL18: straps decide selection, spindle run and indicator.
// RL19: tunnel erase on 200-320 us after, off 860-950 us after.
// RL20: track zero output low only at sensor, phase a, outward.
// RL21: outward steps at track zero are ignored.
// RL22: host keeps direction steady around steps and spaces them.
// RL23: ready clears when speed ok drops or low voltage.
`ifndef FDD_CTL_CFG_SVH
`define FDD_CTL_CFG_SVH

`define ADDR_W 4
`define CFG_OFS 4'h0
`define STAT_OFS 4'h4
`define CFG_TUNNEL_BIT 0
`define CFG_ALWAYS_SEL_BIT 1
`define CFG_MOTOR_SEL_BIT 2
`define CFG_LED_MOTOR_BIT 3
`define CFG_RST 4'h1

`define CLK_MHZ 250
`define ERASE_ON_US 200
`define ERASE_OFF_US 860
`define TDF_DELAY_NS 2400
`define SHAPE_NS 1000
`define STEP2_MS 3
`define OVERDRIVE_MS 75
`define SPEED_MS 400
`define OVERLAP_US 500
`define DIR_IN 1'b1

`define ERASE_ON_CYC (`ERASE_ON_US * `CLK_MHZ)
`define ERASE_OFF_CYC (`ERASE_OFF_US * `CLK_MHZ)
`define TDF_DELAY_CYC ((`TDF_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define SHAPE_CYC ((`SHAPE_NS * `CLK_MHZ + 999) / 1000)
`define STEP2_CYC (`STEP2_MS * `CLK_MHZ * 1000)
`define OVERDRIVE_CYC (`OVERDRIVE_MS * `CLK_MHZ * 1000)
`define SPEED_CYC (`SPEED_MS * `CLK_MHZ * 1000)
`define OVERLAP_CYC (`OVERLAP_US * `CLK_MHZ)

`endif

// file: hw/fdd_ctl_pkg.sv
// types shared by the drive control logic
// assumes nothing beyond the cfg header
package fdd_ctl_pkg;
	typedef enum logic [1:0] {
		lvl_low,
		lvl_middle,
		lvl_high
	} head_level_e;

	typedef struct packed {
		logic a;
		logic b;
		logic a_bar;
		logic b_bar;
	} phase_drive_s;

	typedef struct packed {
		logic led_motor;
		logic motor_sel;
		logic always_sel;
		logic tunnel;
	} strap_s;
endpackage

// file: hw/floppy_drive_control_logic.sv
// drive-side control logic: write/erase gating, read filter, ready,
// stepper sequencing and spindle gate
// assumes all inputs synchronous to ref_clk; straps set over the port
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fdd_ctl_cfg.svh"

module floppy_drive_control_logic
	import fdd_ctl_pkg::*;
#(
	parameter int unsigned ERASE_ON_CYC = `ERASE_ON_CYC,
	parameter int unsigned ERASE_OFF_CYC = `ERASE_OFF_CYC,
	parameter int unsigned TDF_DELAY_CYC = `TDF_DELAY_CYC,
	parameter int unsigned SHAPE_CYC = `SHAPE_CYC,
	parameter int unsigned STEP2_CYC = `STEP2_CYC,
	parameter int unsigned OVERDRIVE_CYC = `OVERDRIVE_CYC,
	parameter int unsigned SPEED_CYC = `SPEED_CYC,
	parameter int unsigned OVERLAP_CYC = `OVERLAP_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic low_voltage_indication,
	// register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// host interface
	input wire logic drive_select_n,
	input wire logic motor_on,
	input wire logic side_select,
	input wire logic write_gate,
	input wire logic write_data,
	input wire logic step,
	input wire logic direction_in,
	output logic read_data_out,
	output logic read_data_oe_n,
	output logic ready_n,
	output logic track_zero_n,
	// sensors
	input wire logic write_enable_notch,
	input wire logic index_pulse,
	input wire logic track0_sensor,
	input wire logic read_pulse,
	// head drive
	output head_level_e side_zero_head_common,
	output head_level_e side_one_head_common,
	output logic write_drive_a,
	output logic write_drive_b,
	output logic erase_drive,
	// motors and indicator
	output phase_drive_s phase_drive,
	output logic overdrive_on,
	output logic spindle_run,
	output logic indicator_on
);

	strap_s strap_ff;
	logic wd_prev_ff, step_prev_ff, idx_prev_ff, rp_prev_ff;
	logic wg_ff, erase_ff, toggle_ff;
	logic [31:0] erase_cnt_ff;
	logic [31:0] tdf_cnt_ff, shape_cnt_ff;
	logic level_ff;
	logic [31:0] speed_cnt_ff;
	logic speed_ok_ff, ready_ff;
	logic [1:0] idx_seen_ff;
	logic dir_ff;
	logic [31:0] step2_cnt_ff, od_cnt_ff, ovl_cnt_ff;
	logic [1:0] pos_ff, old_pos_ff;
	logic selected, wg, writing;
	logic wd_rise, step_rise, step_fall, idx_rise, rp_edge;
	logic step_dir, at_track0, step_req, int_step;
	logic [1:0] nxt_pos;

	function automatic phase_drive_s onehot(input logic [1:0] p);
		phase_drive_s d;
		d = '0;
		case (p)
			2'h0: d.a = 1'b1;
			2'h1: d.b = 1'b1;
			2'h2: d.a_bar = 1'b1;
			default: d.b_bar = 1'b1;
		endcase
		return d;
	endfunction

	// RL18 strapped selection
	assign selected = strap_ff.always_sel | ~drive_select_n;
	assign wd_rise = write_data & ~wd_prev_ff;
	assign step_rise = step & ~step_prev_ff;
	assign step_fall = ~step & step_prev_ff;
	assign idx_rise = index_pulse & ~idx_prev_ff;
	assign rp_edge = read_pulse ^ rp_prev_ff;

	// register port
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			strap_ff <= strap_s'(`CFG_RST);
		end else if (reg_wr && reg_addr == `CFG_OFS) begin
			strap_ff.tunnel <= reg_wdata[`CFG_TUNNEL_BIT];
			strap_ff.always_sel <= reg_wdata[`CFG_ALWAYS_SEL_BIT];
			strap_ff.motor_sel <= reg_wdata[`CFG_MOTOR_SEL_BIT];
			strap_ff.led_motor <= reg_wdata[`CFG_LED_MOTOR_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd && reg_addr == `CFG_OFS) begin
			reg_rdata <= {28'h0, strap_ff};
		end else if (reg_rd && reg_addr == `STAT_OFS) begin
			reg_rdata <= {22'h0, dir_ff, ready_ff, speed_ok_ff, overdrive_on,
				erase_ff, wg_ff, ~track_zero_n, pos_ff, low_voltage_indication};
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// input history for edge detection
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wd_prev_ff <= 1'b0;
			step_prev_ff <= 1'b0;
			idx_prev_ff <= 1'b0;
			rp_prev_ff <= 1'b0;
		end else begin
			wd_prev_ff <= write_data;
			step_prev_ff <= step;
			idx_prev_ff <= index_pulse;
			rp_prev_ff <= read_pulse;
		end
	end

	// RL1 write gate conditions
	// RL9 low voltage inhibit
	assign wg = write_enable_notch & write_gate & selected & ~low_voltage_indication;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wg_ff <= 1'b0;
		end else begin
			wg_ff <= wg;
		end
	end

	// erase gate, straddle or tunnel
	always_ff @(posedge ref_clk) begin
		if (sys_rst || low_voltage_indication) begin
			erase_ff <= 1'b0;
			erase_cnt_ff <= 32'h0;
		end else if (!strap_ff.tunnel) begin
			// RL4 erase follows write
			erase_ff <= wg;
			erase_cnt_ff <= 32'h0;
		end else if (wg_ff == erase_ff) begin
			erase_cnt_ff <= 32'h0;
		end else if (wg_ff && erase_cnt_ff >= ERASE_ON_CYC - 32'h2) begin
			// RL3 delayed erase on
			// RL19 on delay count
			erase_ff <= 1'b1;
			erase_cnt_ff <= 32'h0;
		end else if (!wg_ff && erase_cnt_ff >= ERASE_OFF_CYC - 32'h2) begin
			// RL19 off delay count
			erase_ff <= 1'b0;
			erase_cnt_ff <= 32'h0;
		end else begin
			erase_cnt_ff <= erase_cnt_ff + 32'h1;
		end
	end

	// RL5 alternate write drivers
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !wg) begin
			toggle_ff <= 1'b0;
		end else if (wd_rise) begin
			toggle_ff <= ~toggle_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			write_drive_a <= 1'b0;
			write_drive_b <= 1'b0;
			erase_drive <= 1'b0;
		end else begin
			// RL9 drivers off at low voltage
			write_drive_a <= wg & toggle_ff & ~low_voltage_indication;
			write_drive_b <= wg & ~toggle_ff & ~low_voltage_indication;
			erase_drive <= erase_ff & ~low_voltage_indication;
		end
	end

	// RL2 head common levels
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			side_zero_head_common <= lvl_low;
			side_one_head_common <= lvl_low;
		end else begin
			side_zero_head_common <= lvl_low;
			side_one_head_common <= lvl_low;
			if (wg_ff || erase_ff) begin
				if (side_select) begin
					side_one_head_common <= lvl_high;
				end else begin
					side_zero_head_common <= lvl_high;
				end
			end else if (selected && !low_voltage_indication) begin
				if (side_select) begin
					side_one_head_common <= lvl_middle;
				end else begin
					side_zero_head_common <= lvl_middle;
				end
			end
		end
	end

	assign writing = write_drive_a | write_drive_b;

	// RL7 time domain filter: edges settle for the delay, then
	// a changed level yields one shaped pulse
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tdf_cnt_ff <= 32'h0;
			level_ff <= 1'b0;
		end else if (rp_edge) begin
			tdf_cnt_ff <= TDF_DELAY_CYC;
		end else if (tdf_cnt_ff == 32'h1) begin
			tdf_cnt_ff <= 32'h0;
			level_ff <= read_pulse;
		end else if (tdf_cnt_ff != 32'h0) begin
			tdf_cnt_ff <= tdf_cnt_ff - 32'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || writing) begin
			// RL6 blank during write
			shape_cnt_ff <= 32'h0;
		end else if (tdf_cnt_ff == 32'h1 && read_pulse != level_ff) begin
			shape_cnt_ff <= SHAPE_CYC;
		end else if (shape_cnt_ff != 32'h0) begin
			shape_cnt_ff <= shape_cnt_ff - 32'h1;
		end
	end

	// RL8 three-state read driver
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			read_data_out <= 1'b0;
			read_data_oe_n <= 1'b1;
		end else begin
			read_data_out <= (shape_cnt_ff != 32'h0) & ~writing;
			read_data_oe_n <= ~(selected & ~low_voltage_indication);
		end
	end

	// RL10 retriggered speed counter
	always_ff @(posedge ref_clk) begin
		if (sys_rst || low_voltage_indication) begin
			speed_cnt_ff <= 32'h0;
			speed_ok_ff <= 1'b0;
		end else if (idx_rise) begin
			speed_cnt_ff <= SPEED_CYC;
			speed_ok_ff <= speed_cnt_ff != 32'h0;
		end else if (speed_cnt_ff != 32'h0) begin
			speed_cnt_ff <= speed_cnt_ff - 32'h1;
		end else begin
			speed_ok_ff <= 1'b0;
		end
	end

	// RL11 ready on second index
	// RL23 ready clears with speed ok or low voltage
	always_ff @(posedge ref_clk) begin
		if (sys_rst || low_voltage_indication || !speed_ok_ff) begin
			idx_seen_ff <= 2'h0;
			ready_ff <= 1'b0;
		end else if (idx_rise && idx_seen_ff != 2'h2) begin
			idx_seen_ff <= idx_seen_ff + 2'h1;
			ready_ff <= idx_seen_ff == 2'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ready_n <= 1'b1;
		end else begin
			ready_n <= ~ready_ff;
		end
	end

	// RL12 direction latch
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dir_ff <= `DIR_IN;
		end else if (step_rise) begin
			dir_ff <= direction_in;
		end
	end

	// RL13 delayed second step
	always_ff @(posedge ref_clk) begin
		if (sys_rst || low_voltage_indication) begin
			step2_cnt_ff <= 32'h0;
		end else if (step_fall) begin
			step2_cnt_ff <= STEP2_CYC;
		end else if (step2_cnt_ff != 32'h0) begin
			step2_cnt_ff <= step2_cnt_ff - 32'h1;
		end
	end

	// RL22 host holds direction across the step pair
	assign step_dir = step_rise ? direction_in : dir_ff;
	assign at_track0 = track0_sensor & (pos_ff == 2'h0);
	assign step_req = step_rise | (step2_cnt_ff == 32'h1);
	// RL21 block outward at track zero
	// RL9 steps inhibited at low voltage
	assign int_step = step_req & ~low_voltage_indication & ~(step_dir != `DIR_IN && at_track0);
	assign nxt_pos = (step_dir == `DIR_IN) ? pos_ff + 2'h1 : pos_ff - 2'h1;

	// RL14 phase shift register with overlap
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pos_ff <= 2'h0;
			old_pos_ff <= 2'h0;
			ovl_cnt_ff <= 32'h0;
		end else if (int_step) begin
			pos_ff <= nxt_pos;
			old_pos_ff <= pos_ff;
			ovl_cnt_ff <= OVERLAP_CYC;
		end else if (ovl_cnt_ff != 32'h0) begin
			ovl_cnt_ff <= ovl_cnt_ff - 32'h1;
		end
	end

	// RL15 rest phase by track parity
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			phase_drive <= '0;
		end else if (ovl_cnt_ff != 32'h0) begin
			phase_drive <= onehot(pos_ff) | onehot(old_pos_ff);
		end else begin
			phase_drive <= onehot(pos_ff);
		end
	end

	// RL20 qualified track zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			track_zero_n <= 1'b1;
		end else begin
			track_zero_n <= ~(track0_sensor & (pos_ff == 2'h0) & (dir_ff != `DIR_IN));
		end
	end

	// RL16 retriggered over-drive timer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			od_cnt_ff <= 32'h0;
			overdrive_on <= 1'b0;
		end else if (int_step) begin
			od_cnt_ff <= OVERDRIVE_CYC;
			overdrive_on <= 1'b1;
		end else if (od_cnt_ff > 32'h1) begin
			od_cnt_ff <= od_cnt_ff - 32'h1;
		end else begin
			od_cnt_ff <= 32'h0;
			overdrive_on <= 1'b0;
		end
	end

	// RL17 spindle gate
	// RL18 strapped motor and indicator
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			spindle_run <= 1'b0;
			indicator_on <= 1'b0;
		end else begin
			spindle_run <= motor_on & (~strap_ff.motor_sel | selected) & ~low_voltage_indication;
			indicator_on <= strap_ff.led_motor ? spindle_run : (selected & ~low_voltage_indication);
		end
	end

endmodule
`default_nettype wire

// file: testbench/fdd_ctl_checker_assertions.sv
// assertions on the drive control logic pins
// assumes binding into floppy_drive_control_logic, one clock domain
`timescale 1ns/10ps
`default_nettype none
module fdd_ctl_checker
	import fdd_ctl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// inputs watched
	input wire logic low_voltage_indication,
	input wire logic reg_rd,
	input wire logic side_select,
	input wire logic write_gate,
	input wire logic write_enable_notch,
	input wire logic track0_sensor,
	// outputs watched
	input wire logic [31:0] reg_rdata,
	input wire logic read_data_out,
	input wire logic read_data_oe_n,
	input wire logic ready_n,
	input wire logic track_zero_n,
	input wire logic write_drive_a,
	input wire logic write_drive_b,
	input wire logic erase_drive,
	input wire head_level_e side_zero_head_common,
	input wire head_level_e side_one_head_common,
	input wire phase_drive_s phase_drive,
	input wire logic overdrive_on,
	input wire logic spindle_run
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_writing;
		write_drive_a || write_drive_b;
	endsequence
	sequence s_side0_writing;
		((write_drive_a || write_drive_b) && !side_select) [*3];
	endsequence
	AST_GATE_NEEDS_ALL: assert property ((!write_enable_notch || !write_gate) |=> !write_drive_a && !write_drive_b)
		else $error("write driver on without notch or gate");
	AST_ONE_DRIVER: assert property (!(write_drive_a && write_drive_b))
		else $error("both write drivers on");
	AST_READ_BLANK: assert property (s_writing [*3] |-> !read_data_out)
		else $error("read pulse while writing");
	AST_SIDE_COMMON: assert property (s_side0_writing |-> side_zero_head_common == lvl_high && side_one_head_common == lvl_low)
		else $error("head common level wrong while writing");
	AST_LV_INHIBIT: assert property (low_voltage_indication |=> !write_drive_a && !write_drive_b && !erase_drive && !spindle_run)
		else $error("low voltage did not inhibit");
	AST_LV_READY: assert property (low_voltage_indication |-> ##2 ready_n)
		else $error("ready stayed on at low voltage");
	AST_LV_OE: assert property (low_voltage_indication |=> read_data_oe_n)
		else $error("read driver on at low voltage");
	AST_TZ_SENSOR: assert property (!track0_sensor [*2] |-> track_zero_n)
		else $error("track zero without sensor");
	AST_PHASE_PAIR: assert property (!(phase_drive.a && phase_drive.a_bar) && !(phase_drive.b && phase_drive.b_bar))
		else $error("opposite phases together");
	AST_OD_HOLD: assert property ($rose(overdrive_on) |-> overdrive_on [*8])
		else $error("overdrive too short");
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
endmodule
bind floppy_drive_control_logic fdd_ctl_checker u_chk (.ref_clk, .sys_rst, .low_voltage_indication, .reg_rd,
	.side_select, .write_gate, .write_enable_notch, .track0_sensor, .reg_rdata, .read_data_out, .read_data_oe_n,
	.ready_n, .track_zero_n, .write_drive_a, .write_drive_b, .erase_drive, .side_zero_head_common,
	.side_one_head_common, .phase_drive, .overdrive_on, .spindle_run);
`default_nettype wire

// file: testbench/host_step_model.sv
// host side stepping: direction then one step pulse per request
// assumes requests only while busy is low
`timescale 1ns/10ps
`default_nettype none
module host_step_model (
	// requests from bench
	input wire logic ref_clk,
	input wire logic go,
	input wire logic dir,
	output logic busy,
	// drive interface
	output logic step,
	output logic direction_in
);
	int cnt;
	initial begin
		cnt = 0;
		step = 1'h0;
		direction_in = 1'h0;
	end
	always @(posedge ref_clk) begin
		if (cnt == 0 && go) begin
			cnt <= 1;
			direction_in <= dir;
		end else if (cnt != 0)
			cnt <= (cnt == 120) ? 0 : cnt + 1;
		step <= (cnt >= 2 && cnt < 5);
	end
	assign busy = (cnt != 0);
endmodule
`default_nettype wire

// file: testbench/floppy_drive_control_logic_test.sv
// self-checking bench for the drive control logic
// assumes the host step model and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "fdd_ctl_cfg.svh"
module floppy_drive_control_logic_test
	import fdd_ctl_pkg::*;
;
	logic ref_clk = 1'h0, sys_rst = 1'h1, low_voltage_indication = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [`ADDR_W-1:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, r = 32'hdd3d;
	logic drive_select_n = 1'h1, motor_on = 1'h0, side_select = 1'h0, write_gate = 1'h0, write_data = 1'h0;
	logic write_enable_notch = 1'h0, index_pulse = 1'h0, track0_sensor = 1'h0, read_pulse = 1'h0;
	logic go = 1'h0, dir = 1'h0, busy, step, direction_in, read_data_out, read_data_oe_n, ready_n, track_zero_n;
	logic write_drive_a, write_drive_b, erase_drive, overdrive_on, spindle_run, indicator_on, rd_d = 1'h0, rdo_d = 1'h0;
	head_level_e side_zero_head_common, side_one_head_common;
	phase_drive_s phase_drive;
	logic [31:0] exp_q[$], msk_q[$];
	int failures = 0, n_checks = 0, n_rd = 0, n0, k;
	always #2 ref_clk = ~ref_clk;
	// erase on delay, read filter and pulse shaper run at full length
	floppy_drive_control_logic #(.ERASE_OFF_CYC(40), .STEP2_CYC(50), .OVERDRIVE_CYC(200), .SPEED_CYC(300),
		.OVERLAP_CYC(5)) u_dut (.ref_clk, .sys_rst,
		.low_voltage_indication, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .drive_select_n, .motor_on,
		.side_select, .write_gate, .write_data, .step, .direction_in, .read_data_out, .read_data_oe_n, .ready_n,
		.track_zero_n, .write_enable_notch, .index_pulse, .track0_sensor, .read_pulse, .side_zero_head_common,
		.side_one_head_common, .write_drive_a, .write_drive_b, .erase_drive, .phase_drive, .overdrive_on,
		.spindle_run, .indicator_on);
	host_step_model u_host (.ref_clk, .go, .dir, .busy, .step, .direction_in);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		cyc(1);
		reg_wr <= 1'h0;
		cyc(1);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		reg_addr <= a;
		reg_rd <= 1'h1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		cyc(1);
		reg_rd <= 1'h0;
		cyc(1);
	endtask
	// one host step: phase checked mid-way and at rest
	task stp(input logic d, input logic [3:0] mid, input logic [3:0] fin);
		dir <= d;
		go <= 1'h1;
		cyc(1);
		go <= 1'h0;
		cyc(20);
		chk(phase_drive, mid);
		repeat (300) begin
			cyc(1);
			if (!busy)
				break;
		end
		chk(phase_drive, fin);
	endtask
	task ix(input int n);
		repeat (n) begin
			index_pulse <= 1'h1;
			cyc(1);
			index_pulse <= 1'h0;
			cyc(99);
		end
	endtask
	task stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// read data scoreboard and read pulse count
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		rdo_d <= read_data_out;
		if (read_data_out === 1'h1 && rdo_d === 1'h0)
			n_rd++;
		if (rd_d)
			chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
	end
	// full erase on delay dominates: about 56000 cycles expected
	initial begin
		#300000;
		failures++;
		stop_test;
	end
	initial begin
		cyc(3);
		sys_rst <= 1'h0;
		cyc(2);
		chk(phase_drive, 4'h8);
		rd(`CFG_OFS, 32'h1, 32'hffffffff);
		r = lfsr(r);
		wr(`CFG_OFS, r & 32'h3);
		rd(`CFG_OFS, r & 32'h3, 32'hffffffff);
		wr(4'h8, 32'hffffffff);
		rd(4'h8, 32'h0, 32'hffffffff);
		wr(`STAT_OFS, 32'hffffffff);
		rd(`STAT_OFS, 32'h0, 32'h1);
		$display("test registers done");
		wr(`CFG_OFS, 32'h0);
		motor_on <= 1'h1;
		drive_select_n <= 1'h0;
		cyc(3);
		chk(spindle_run, 1'h1);
		chk(read_data_oe_n, 1'h0);
		chk(indicator_on, 1'h1);
		chk(side_zero_head_common, lvl_middle);
		chk(side_one_head_common, lvl_low);
		$display("test spindle done");
		n0 = n_rd;
		r = lfsr(r);
		k = r[1:0] + 1;
		repeat (k) begin
			read_pulse <= ~read_pulse;
			cyc(`TDF_DELAY_CYC + `SHAPE_CYC + 8);
		end
		chk(n_rd - n0, k);
		read_pulse <= ~read_pulse;
		cyc(2);
		read_pulse <= ~read_pulse;
		cyc(`TDF_DELAY_CYC + `SHAPE_CYC + 8);
		chk(n_rd - n0, k);
		$display("test read filter done");
		write_enable_notch <= 1'h1;
		write_gate <= 1'h1;
		cyc(4);
		chk(write_drive_b, 1'h1);
		chk(erase_drive, 1'h1);
		chk(side_zero_head_common, lvl_high);
		chk(side_one_head_common, lvl_low);
		write_data <= 1'h1;
		cyc(1);
		write_data <= 1'h0;
		n0 = n_rd;
		read_pulse <= ~read_pulse;
		cyc(4);
		chk(write_drive_a, 1'h1);
		cyc(`TDF_DELAY_CYC + `SHAPE_CYC + 8);
		chk(n_rd - n0, 0);
		drive_select_n <= 1'h1;
		cyc(3);
		chk(write_drive_a, 1'h0);
		wr(`CFG_OFS, 32'h2);
		side_select <= 1'h1;
		cyc(2);
		chk(write_drive_a | write_drive_b, 1'h1);
		chk(side_one_head_common, lvl_high);
		chk(side_zero_head_common, lvl_low);
		low_voltage_indication <= 1'h1;
		cyc(3);
		chk({write_drive_a, write_drive_b, erase_drive}, 3'h0);
		rd(`STAT_OFS, 32'h1, 32'h1);
		low_voltage_indication <= 1'h0;
		write_gate <= 1'h0;
		$display("test write done");
		wr(`CFG_OFS, 32'h3);
		cyc(60);
		write_gate <= 1'h1;
		cyc(`ERASE_ON_CYC - 5);
		chk(erase_drive, 1'h0);
		cyc(10);
		chk(erase_drive, 1'h1);
		write_gate <= 1'h0;
		cyc(30);
		chk(erase_drive, 1'h1);
		cyc(15);
		chk(erase_drive, 1'h0);
		$display("test erase delay done");
		drive_select_n <= 1'h0;
		stp(`DIR_IN, 4'h4, 4'h2);
		chk(overdrive_on, 1'h1);
		stp(~`DIR_IN, 4'h4, 4'h8);
		chk(track_zero_n, 1'h1);
		track0_sensor <= 1'h1;
		cyc(3);
		chk(track_zero_n, 1'h0);
		stp(~`DIR_IN, 4'h8, 4'h8);
		cyc(250);
		chk(overdrive_on, 1'h0);
		$display("test stepper done");
		ix(3);
		chk(ready_n, 1'h1);
		ix(1);
		chk(ready_n, 1'h0);
		rd(`STAT_OFS, 32'h180, 32'h180);
		cyc(320);
		chk(ready_n, 1'h1);
		ix(4);
		chk(ready_n, 1'h0);
		low_voltage_indication <= 1'h1;
		cyc(3);
		chk(ready_n, 1'h1);
		chk(spindle_run, 1'h0);
		low_voltage_indication <= 1'h0;
		motor_on <= 1'h0;
		cyc(3);
		chk(spindle_run, 1'h0);
		chk(indicator_on, 1'h1);
		$display("test ready done");
		stop_test;
	end
endmodule
`default_nettype wire
